// ### common/scu_pkg.sv
// shared constants and types of the shift/cycle unit
// assumes a 50 MHz processor clock and an APB register slave

package scu_pkg;
    // register word offsets on the APB side (byte addresses)
    localparam logic [7:0] OFS_A = 8'h00;
    localparam logic [7:0] OFS_B = 8'h04;
    localparam logic [7:0] OFS_CMD = 8'h08;
    localparam logic [7:0] OFS_STAT = 8'h0C;
    // status register bits
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_OVF_BIT = 1;
    // operand field positions (vector index, index 23 is the word's bit 0)
    localparam int CNT_MSB = 8;
    localparam int LOG_BIT = 9;
    localparam int CYC_BIT = 10;
    localparam int DIR_BIT = 11;
    localparam int SEL_LO = 12;
    localparam int SEL_HI = 13;
    localparam int NORM_BIT = 14;
    // register selection codes
    localparam logic [1:0] SEL_DOUBLE = 2'h0;
    localparam logic [1:0] SEL_B_ONLY = 2'h1;
    localparam logic [1:0] SEL_A_ONLY = 2'h2;
    localparam logic [1:0] SEL_TWIN = 2'h3;
    // count limit and timing breakpoints
    localparam logic [8:0] MAX_COUNT = 9'h030;
    localparam logic [8:0] LEFT_LIM2 = 9'h006;
    localparam logic [8:0] LEFT_LIM3 = 9'h01C;
    localparam logic [8:0] RIGHT_LIM2 = 9'h003;
    localparam logic [8:0] RIGHT_LIM3 = 9'h00E;
    localparam logic [8:0] RIGHT_LIM4 = 9'h019;
    localparam logic [8:0] RIGHT_LIM5 = 9'h024;
    localparam logic [8:0] RIGHT_LIM6 = 9'h02F;
    localparam logic [2:0] NORM_MEM_CYCLES = 3'h2;
    // memory cycle expressed in clocks (a least time, rounded up)
    localparam int CLK_PERIOD_NS = 20;
    localparam int MEM_CYCLE_NS = 1750;
    localparam int MEM_CYCLE_CLKS =
        (MEM_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic {SCU_IDLE, SCU_RUN} scu_phase_t;

    typedef struct packed {
        scu_phase_t phase;
        logic [23:0] a;
        logic [23:0] b;
        logic [5:0] cnt;
        logic [1:0] sel;
        logic left;
        logic cyc;
        logic logical;
        logic sign0;
        logic [9:0] timer;
        logic ovf;
        logic done;
        logic [31:0] rdata;
    } scu_state_t;
endpackage

// ### core/scu_core.sv
// shift/cycle unit: A and B accumulators, double and twin shifts over APB
// assumes an APB master on CLK_IN; the sequencer waits for DONE_OUT
// Overview of operation
// RULE_01 - double right: A bit 23 into B bit 0
// RULE_02 - double left: B bit 0 into A bit 23
// RULE_03 - operand bit 9 set means normalize; the code does no shift and only waits 2 memory cycles
// RULE_04 - bits 10-11 pick double, B, A, twin
// RULE_05 - bits 12-14: direction, shift/cycle, arith/logical
// RULE_06 - arithmetic right keeps and extends sign
// RULE_07 - arithmetic left on A sets overflow
// RULE_08 - arithmetic left on B never sets overflow
// RULE_09 - logical shifts fill vacated bits with zero
// RULE_10 - logical treats 24 or 48 bits whole
// RULE_11 - twin mode shifts A, B independently
// RULE_12 - cycle wraps leaving bits to other end
// RULE_13 - count is unsigned operand bits 15-23
// RULE_14 - zero count leaves registers unchanged
// RULE_15 - count above 48 becomes 48
// RULE_16 - count decrements once per bit shifted
// RULE_17 - left shift takes 2, 3, 4 cycles
// RULE_18 - right shift takes 2 to 7 cycles
// RULE_19 - address logic indexes 15 or 9 bits
// RULE_20 - sequencer never repeats shift instructions
// RULE_21 - single right drops bits past 23
// RULE_22 - double arithmetic right extends only A sign
// RULE_23 - double cycle right: B 23 to A 0
// RULE_24 - overflow changes only on arithmetic left A; the code also clears it on a STAT write with bit 1 set
// RULE_25 - completion pulse after the memory-cycle time

`timescale 1ns/1ps

module scu_core
    import scu_pkg::*;
(
    input wire logic CLK_IN,
    input wire logic RESET_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [7:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    output logic BUSY_OUT,
    output logic DONE_OUT,
    output logic OVERFLOW_OUT
);

    scu_state_t st_reg;
    scu_state_t st_next;
    logic setup;
    logic access;
    logic mapped;
    logic stepping;

    // one bit of a single register: left or right, shift or cycle
    function automatic logic [23:0] step_one(input logic [23:0] r,
        input logic left, input logic cyc, input logic logical);
        logic fill;
        fill = 1'b0;
        if (left)
        begin
            fill = cyc ? r[23] : 1'b0; // RULE_09 RULE_12
            return {r[22:0], fill};
        end
        if (cyc)
            fill = r[0]; // RULE_12
        else if (!logical)
            fill = r[23]; // RULE_06
        return {fill, r[23:1]}; // RULE_21
    endfunction

    // memory cycles needed for a given direction and count
    function automatic logic [2:0] mem_cycles(input logic left,
        input logic [8:0] c);
        if (left)
        begin
            if (c <= LEFT_LIM2) return 3'h2; // RULE_17
            if (c <= LEFT_LIM3) return 3'h3;
            return 3'h4;
        end
        if (c <= RIGHT_LIM2) return 3'h2; // RULE_18
        if (c <= RIGHT_LIM3) return 3'h3;
        if (c <= RIGHT_LIM4) return 3'h4;
        if (c <= RIGHT_LIM5) return 3'h5;
        if (c <= RIGHT_LIM6) return 3'h6;
        return 3'h7;
    endfunction

    // apb phase decode and address map
    assign setup = PSEL_IN && !PENABLE_IN;
    assign access = PSEL_IN && PENABLE_IN;
    assign mapped = (PADDR_IN == OFS_A) || (PADDR_IN == OFS_B) ||
        (PADDR_IN == OFS_CMD) || (PADDR_IN == OFS_STAT);
    assign stepping = (st_reg.phase == SCU_RUN) && (st_reg.cnt != 6'h00);

    // next state: bus side, command start, one bit per clock while running
    always_comb
    begin
        logic [8:0] raw;
        logic [8:0] eff;
        logic [47:0] d;
        logic fill;
        raw = PWDATA_IN[CNT_MSB:0]; // RULE_13
        eff = '0;
        d = '0;
        fill = 1'b0;
        st_next = st_reg;
        st_next.done = 1'b0;
        if (setup)
        begin
            st_next.rdata = '0;
            case (PADDR_IN)
                OFS_A: st_next.rdata[23:0] = st_reg.a;
                OFS_B: st_next.rdata[23:0] = st_reg.b;
                OFS_STAT:
                begin
                    st_next.rdata[STAT_BUSY_BIT] = st_reg.phase == SCU_RUN;
                    st_next.rdata[STAT_OVF_BIT] = st_reg.ovf;
                end
                default: st_next.rdata = '0;
            endcase
        end
        // writes take effect at the access edge; data writes are ignored while running
        if (access && PWRITE_IN && mapped)
        begin
            case (PADDR_IN)
                OFS_A:
                    if (st_reg.phase == SCU_IDLE)
                        st_next.a = PWDATA_IN[23:0];
                OFS_B:
                    if (st_reg.phase == SCU_IDLE)
                        st_next.b = PWDATA_IN[23:0];
                OFS_STAT:
                    if (PWDATA_IN[STAT_OVF_BIT])
                        st_next.ovf = 1'b0;
                OFS_CMD:
                    if (st_reg.phase == SCU_IDLE)
                    begin
                        st_next.phase = SCU_RUN;
                        st_next.sel = PWDATA_IN[SEL_HI:SEL_LO]; // RULE_04
                        st_next.left = PWDATA_IN[DIR_BIT]; // RULE_05
                        st_next.cyc = PWDATA_IN[CYC_BIT];
                        st_next.logical = PWDATA_IN[LOG_BIT];
                        st_next.sign0 = st_reg.a[23];
                        eff = (raw > MAX_COUNT) ? MAX_COUNT : raw; // RULE_15
                        if (PWDATA_IN[NORM_BIT])
                        begin
                            // normalize is not carried out here: no shift
                            st_next.cnt = '0; // RULE_03
                            st_next.timer = 10'(NORM_MEM_CYCLES) *
                                10'(MEM_CYCLE_CLKS);
                        end
                        else
                        begin
                            st_next.cnt = eff[5:0]; // RULE_14
                            st_next.timer =
                                10'(mem_cycles(PWDATA_IN[DIR_BIT], eff)) *
                                10'(MEM_CYCLE_CLKS); // RULE_17 RULE_18
                        end
                    end
                default: st_next.phase = st_reg.phase;
            endcase
        end
        // running: shift one position per clock, then wait out the time
        if (st_reg.phase == SCU_RUN)
        begin
            if (stepping)
            begin
                st_next.cnt = st_reg.cnt - 6'h01; // RULE_16
                case (st_reg.sel)
                    SEL_DOUBLE:
                    begin
                        d = {st_reg.a, st_reg.b}; // RULE_10
                        if (st_reg.left)
                            d = {d[46:0], st_reg.cyc ? d[47] : 1'b0}; // RULE_02
                        else
                        begin
                            if (st_reg.cyc)
                                fill = d[0]; // RULE_23
                            else if (!st_reg.logical)
                                fill = d[47]; // RULE_22
                            d = {fill, d[47:1]}; // RULE_01
                        end
                        st_next.a = d[47:24];
                        st_next.b = d[23:0];
                    end
                    SEL_A_ONLY:
                        st_next.a = step_one(st_reg.a, st_reg.left,
                            st_reg.cyc, st_reg.logical);
                    SEL_B_ONLY:
                        st_next.b = step_one(st_reg.b, st_reg.left,
                            st_reg.cyc, st_reg.logical);
                    default:
                    begin
                        // twin: both move, nothing crosses between them
                        st_next.a = step_one(st_reg.a, st_reg.left,
                            st_reg.cyc, st_reg.logical); // RULE_11
                        st_next.b = step_one(st_reg.b, st_reg.left,
                            st_reg.cyc, st_reg.logical);
                    end
                endcase
                // overflow only for arithmetic left shifts touching A
                if (st_reg.left && !st_reg.cyc && !st_reg.logical &&
                    st_reg.sel != SEL_B_ONLY &&
                    st_next.a[23] != st_reg.sign0)
                    st_next.ovf = 1'b1; // RULE_07 RULE_08 RULE_24
            end
            st_next.timer = st_reg.timer - 10'h001;
            if (st_reg.timer == 10'h001)
            begin
                st_next.phase = SCU_IDLE;
                st_next.done = 1'b1; // RULE_25
            end
        end
    end

    // state register
    always_ff @(posedge CLK_IN)
    begin
        if (RESET_IN)
        begin
            st_reg <= '0;
            st_reg.phase <= SCU_IDLE;
        end
        else
            st_reg <= st_next;
    end

    // outputs
    assign PRDATA_OUT = st_reg.rdata;
    assign PREADY_OUT = 1'b1;
    assign PSLVERR_OUT = access && !mapped;
    assign BUSY_OUT = st_reg.phase == SCU_RUN;
    assign DONE_OUT = st_reg.done;
    assign OVERFLOW_OUT = st_reg.ovf;

    // helper: busy clocks since start and the time that was promised
    logic [9:0] elapsed_reg;
    logic [9:0] expect_reg;
    always_ff @(posedge CLK_IN)
    begin
        if (RESET_IN)
        begin
            elapsed_reg <= '0;
            expect_reg <= '0;
        end
        else if (st_reg.phase == SCU_IDLE && st_next.phase == SCU_RUN)
        begin
            elapsed_reg <= '0;
            expect_reg <= st_next.timer;
        end
        else if (st_reg.phase == SCU_RUN)
            elapsed_reg <= elapsed_reg + 10'h001;
    end

    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (RESET_IN);

    chk_count_clamp: assert property ( // RULE_15
        (st_reg.phase == SCU_IDLE && access && PWRITE_IN &&
        PADDR_IN == OFS_CMD && !PWDATA_IN[NORM_BIT] &&
        PWDATA_IN[CNT_MSB:0] > MAX_COUNT) |=> st_reg.cnt == 6'h30)
        else $error("count not clamped to 48");
    chk_count_step: assert property ( // RULE_16
        stepping |=> st_reg.cnt == $past(st_reg.cnt) - 6'h01)
        else $error("count did not step down by one");
    chk_zero_hold: assert property ( // RULE_14
        (st_reg.phase == SCU_RUN && st_reg.cnt == 6'h00) |=>
        $stable(st_reg.a) && $stable(st_reg.b))
        else $error("registers moved with zero count");
    chk_double_right: assert property ( // RULE_01
        (stepping && st_reg.sel == SEL_DOUBLE && !st_reg.left) |=>
        st_reg.b[23] == $past(st_reg.a[0]))
        else $error("A low bit did not enter B");
    chk_double_left: assert property ( // RULE_02
        (stepping && st_reg.sel == SEL_DOUBLE && st_reg.left) |=>
        st_reg.a[0] == $past(st_reg.b[23]))
        else $error("B top bit did not enter A");
    chk_sign_extend: assert property ( // RULE_06
        (stepping && !st_reg.left && !st_reg.cyc && !st_reg.logical &&
        st_reg.sel != SEL_B_ONLY) |=>
        st_reg.a[23] == $past(st_reg.a[23]) &&
        st_reg.a[22] == $past(st_reg.a[23]))
        else $error("sign of A not extended");
    chk_logic_fill: assert property ( // RULE_09
        (stepping && !st_reg.left && !st_reg.cyc && st_reg.logical &&
        st_reg.sel == SEL_TWIN) |=> st_reg.a[23] == 1'b0 &&
        st_reg.b[23] == 1'b0)
        else $error("logical shift did not fill zero");
    chk_cycle_wrap: assert property ( // RULE_12
        (stepping && !st_reg.left && st_reg.cyc &&
        st_reg.sel == SEL_A_ONLY) |=> st_reg.a[23] == $past(st_reg.a[0]))
        else $error("cycle lost a bit");
    chk_ovf_b_only: assert property ( // RULE_08
        (st_reg.phase == SCU_RUN && st_reg.sel == SEL_B_ONLY) |=>
        !st_reg.ovf || $past(st_reg.ovf))
        else $error("overflow set by B shift");
    chk_ovf_set: assert property ( // RULE_07
        (stepping && st_reg.left && !st_reg.cyc && !st_reg.logical &&
        st_reg.sel == SEL_A_ONLY && st_reg.a[22] != st_reg.sign0) |=>
        st_reg.ovf)
        else $error("overflow missed on sign change");
    chk_done_time: assert property ( // RULE_17 RULE_18 RULE_25
        DONE_OUT |-> elapsed_reg == expect_reg && !BUSY_OUT)
        else $error("completion at wrong time");
    chk_done_single: assert property ( // RULE_25
        DONE_OUT |=> !DONE_OUT)
        else $error("completion pulse longer than one cycle");

    // command capture: count field, normalize request, operation fields
    chk_count_take: assert property ( // RULE_13
        (st_reg.phase == SCU_IDLE && access && PWRITE_IN &&
        PADDR_IN == OFS_CMD && !PWDATA_IN[NORM_BIT] &&
        PWDATA_IN[CNT_MSB:0] <= MAX_COUNT) |=>
        st_reg.cnt == $past(PWDATA_IN[5:0]))
        else $error("count not taken from operand");
    chk_norm_still: assert property ( // RULE_03
        (st_reg.phase == SCU_IDLE && access && PWRITE_IN &&
        PADDR_IN == OFS_CMD && PWDATA_IN[NORM_BIT]) |=>
        st_reg.phase == SCU_RUN && st_reg.cnt == 6'h00)
        else $error("normalize request started a shift");
    chk_mode_latch: assert property ( // RULE_04 RULE_05
        (st_reg.phase == SCU_IDLE && access && PWRITE_IN &&
        PADDR_IN == OFS_CMD) |=>
        st_reg.sel == $past(PWDATA_IN[SEL_HI:SEL_LO]) &&
        st_reg.left == $past(PWDATA_IN[DIR_BIT]) &&
        st_reg.cyc == $past(PWDATA_IN[CYC_BIT]) &&
        st_reg.logical == $past(PWDATA_IN[LOG_BIT]))
        else $error("operation fields not latched");

    // right shifts: bits past the low end go, the ring closes on a cycle
    chk_single_drop: assert property ( // RULE_21
        (stepping && !st_reg.left && st_reg.sel == SEL_A_ONLY) |=>
        st_reg.a[22:0] == $past(st_reg.a[23:1]))
        else $error("single right shift misplaced bits");
    chk_b_sign_moves: assert property ( // RULE_22
        (stepping && !st_reg.left && !st_reg.cyc && !st_reg.logical &&
        st_reg.sel == SEL_DOUBLE) |=> st_reg.b[22] == $past(st_reg.b[23]))
        else $error("B sign did not move in double shift");
    chk_ring_close: assert property ( // RULE_23
        (stepping && !st_reg.left && st_reg.cyc &&
        st_reg.sel == SEL_DOUBLE) |=> st_reg.a[23] == $past(st_reg.b[0]))
        else $error("double cycle lost the B end bit");
    chk_logic_whole: assert property ( // RULE_10
        (stepping && !st_reg.left && !st_reg.cyc && st_reg.logical &&
        st_reg.sel == SEL_DOUBLE) |=> st_reg.a[23] == 1'b0 &&
        st_reg.b[23] == $past(st_reg.a[0]))
        else $error("double logical shift not one unit");

    // left shifts: zeros in on the right, or the wrap on a cycle
    chk_left_zero: assert property ( // RULE_09
        (stepping && st_reg.left && !st_reg.cyc &&
        st_reg.sel == SEL_A_ONLY) |=> st_reg.a[0] == 1'b0)
        else $error("left shift did not fill zero");
    chk_left_wrap: assert property ( // RULE_12
        (stepping && st_reg.left && st_reg.cyc &&
        st_reg.sel == SEL_A_ONLY) |=> st_reg.a[0] == $past(st_reg.a[23]))
        else $error("left cycle lost a bit");
    chk_twin_apart: assert property ( // RULE_11
        (stepping && st_reg.left && !st_reg.cyc &&
        st_reg.sel == SEL_TWIN) |=> st_reg.a[0] == 1'b0 &&
        st_reg.b[0] == 1'b0)
        else $error("bit crossed between twin registers");

    // overflow is never set outside arithmetic left shifts
    chk_ovf_steady: assert property ( // RULE_24
        (st_reg.phase == SCU_RUN &&
        (!st_reg.left || st_reg.cyc || st_reg.logical)) |=>
        !st_reg.ovf || $past(st_reg.ovf))
        else $error("overflow set outside arithmetic left");

    cov_double_left: cover property (
        stepping && st_reg.sel == SEL_DOUBLE && st_reg.left);
    cov_twin_cycle: cover property (
        stepping && st_reg.sel == SEL_TWIN && st_reg.cyc);
    cov_ovf_rise: cover property ($rose(st_reg.ovf));
    cov_done: cover property (DONE_OUT);
    cov_zero_count: cover property (
        st_reg.phase == SCU_RUN && st_reg.cnt == 6'h00);

endmodule // scu_core

// ### sim/scu_seq_model.sv
// sequencer model: APB master that hands operands to the shift unit
// assumes one clock; the bench calls xfer for every register access
`timescale 1ns/1ps

module scu_seq_model
(
    input wire logic clk_in,
    input wire logic pready_in,
    input wire logic pslverr_in,
    input wire logic [31:0] prdata_in,
    output logic psel_out,
    output logic penable_out,
    output logic pwrite_out,
    output logic [7:0] paddr_out,
    output logic [31:0] pwdata_out
);
    // bus idle from time zero
    initial
    begin
        psel_out = 1'b0;
        penable_out = 1'b0;
        pwrite_out = 1'b0;
        paddr_out = 8'h00;
        pwdata_out = 32'h0000_0000;
    end

    // one access, never replayed: setup, access held until ready
    task automatic xfer(input logic wr, input logic [7:0] addr,
        input logic [31:0] wd, output logic [31:0] rd, output logic err);
        @(posedge clk_in);
        psel_out <= 1'b1;
        penable_out <= 1'b0;
        pwrite_out <= wr;
        paddr_out <= addr;
        pwdata_out <= wd;
        @(posedge clk_in);
        penable_out <= 1'b1;
        // the wait ends once pready_in is 1; the bench's run ceiling ends it if that never comes
        do
            @(posedge clk_in);
        while (pready_in !== 1'b1);
        rd = prdata_in;
        err = pslverr_in;
        // released lines stop showing the old request
        psel_out <= 1'b0;
        penable_out <= 1'b0;
        pwrite_out <= ~wr;
        paddr_out <= ~addr;
        pwdata_out <= ~wd;
    endtask
endmodule // scu_seq_model

// ### sim/tb_top.sv
// self-checking bench for the shift/cycle unit, driven over APB
// assumes scu_pkg, scu_core and scu_seq_model are compiled before it
`timescale 1ns/1ps

module tb_top
    import scu_pkg::*;
;
    localparam logic [23:0] P1 = 24'h81_F531;
    localparam logic [23:0] P2 = 24'h5A_0F3C;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel, penable, pwrite, pready, pslverr, busy, done, ovf, err;
    logic exp_ovf = 1'b0;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    int errors = 0;
    int n_compared = 0;
    int cycles = 0;
    int cnt_list [16] = '{0, 1, 3, 4, 6, 7, 14, 15, 28, 29, 36, 37, 47,
        48, 300, 511};

    scu_seq_model i_seq (.clk_in(clk), .pready_in(pready),
        .pslverr_in(pslverr), .prdata_in(prdata), .psel_out(psel),
        .penable_out(penable), .pwrite_out(pwrite), .paddr_out(paddr),
        .pwdata_out(pwdata));
    scu_core i_dut (.CLK_IN(clk), .RESET_IN(rst), .PSEL_IN(psel),
        .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
        .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
        .PSLVERR_OUT(pslverr), .BUSY_OUT(busy), .DONE_OUT(done),
        .OVERFLOW_OUT(ovf));

    // clock and a ceiling on the run length
    always #10 clk = ~clk;
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 40000)
        begin
            errors = errors + 1;
            end_of_test();
        end
    end

    // verdict and end of run
    task automatic end_of_test();
        $display("compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // compare one value
    task automatic check(input string what, input logic [31:0] seen, exp);
        n_compared++;
        if (seen !== exp)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // operand word: only the 9-bit count field carries the amount
    function automatic logic [14:0] cmd(input logic [1:0] s,
        input logic [2:0] t, input logic [8:0] n);
        return {1'b0, s, t, n};
    endfunction

    // one bit step of a w-bit register: left, cycle, logical
    function automatic logic [47:0] st(input logic [47:0] r, input int w,
        input logic l, y, g);
        logic f;
        f = y ? (l ? r[w-1] : r[0]) : (l || g ? 1'b0 : r[w-1]);
        if (l)
            r = {r[46:0], 1'b0} | 48'(f);
        else
            r = (r >> 1) | (48'(f) << (w - 1));
        return w == 48 ? r : r & 48'h0000_00FF_FFFF;
    endfunction

    // expected registers, overflow and memory cycles of one operation
    function automatic void model(input logic [14:0] c,
        input logic [23:0] a0, b0, output logic [23:0] a, b,
        output logic ov, output int mc);
        int n;
        logic l, y, g;
        {l, y, g} = c[11:9];
        n = c[14] ? 0 : (c[8:0] > 48 ? 48 : int'(c[8:0]));
        a = a0;
        b = b0;
        ov = 1'b0;
        for (int i = 0; i < n; i++)
        begin
            if (c[13:12] == SEL_DOUBLE)
                {a, b} = st({a, b}, 48, l, y, g);
            if (c[13:12] == SEL_A_ONLY || c[13:12] == SEL_TWIN)
                a = 24'(st(48'(a), 24, l, y, g));
            if (c[13:12] == SEL_B_ONLY || c[13:12] == SEL_TWIN)
                b = 24'(st(48'(b), 24, l, y, g));
            if (c[13:12] != SEL_B_ONLY && l && !y && !g && a[23] != a0[23])
                ov = 1'b1;
        end
        if (c[14])
            mc = int'(NORM_MEM_CYCLES);
        else if (l)
            mc = n <= 6 ? 2 : n <= 28 ? 3 : 4;
        else
            mc = n <= 3 ? 2 : n <= 14 ? 3 : n <= 25 ? 4 : n <= 36 ? 5 :
                n <= 47 ? 6 : 7;
    endfunction

    // load A and B, start, optionally poke while busy, then judge
    task automatic run_op(input logic [14:0] c, input logic [23:0] a0, b0,
        input logic poke = 1'b0);
        logic [23:0] ea, eb;
        logic ov;
        int mc, n, k;
        model(c, a0, b0, ea, eb, ov, mc);
        exp_ovf = exp_ovf | ov;
        i_seq.xfer(1'b1, OFS_A, {8'h00, a0}, rdat, err);
        i_seq.xfer(1'b1, OFS_B, {8'h00, b0}, rdat, err);
        i_seq.xfer(1'b1, OFS_CMD, {17'h0_0000, c}, rdat, err);
        n = 0;
        if (poke)
        begin
            i_seq.xfer(1'b0, OFS_STAT, 32'h0000_0000, rdat, err);
            check("busy bit", rdat[STAT_BUSY_BIT], 1'b1);
            i_seq.xfer(1'b1, OFS_A, 32'h0000_1234, rdat, err);
            i_seq.xfer(1'b1, OFS_CMD, 32'h0000_0000, rdat, err);
            n = 9;
        end
        k = 0;
        while (k < 700 && !(n > 0 && busy !== 1'b1))
        begin
            @(posedge clk);
            k++;
            if (busy === 1'b1)
                n++;
        end
        check("busy clocks", n, mc * MEM_CYCLE_CLKS);
        check("done pulse", done, 1'b1);
        i_seq.xfer(1'b0, OFS_A, 32'h0000_0000, rdat, err);
        check("reg a", rdat, {8'h00, ea});
        i_seq.xfer(1'b0, OFS_B, 32'h0000_0000, rdat, err);
        check("reg b", rdat, {8'h00, eb});
        i_seq.xfer(1'b0, OFS_STAT, 32'h0000_0000, rdat, err);
        check("stat", rdat, {30'h0000_0000, exp_ovf, 1'b0});
        check("overflow pin", ovf, exp_ovf);
    endtask

    // idle outputs, write-only command, unmapped access
    task automatic t_regs();
        check("busy idle", busy, 1'b0);
        check("ovf idle", ovf, 1'b0);
        i_seq.xfer(1'b0, OFS_CMD, 32'h0000_0000, rdat, err);
        check("cmd read", rdat, 32'h0000_0000);
        check("mapped err", err, 1'b0);
        i_seq.xfer(1'b0, 8'h10, 32'h0000_0000, rdat, err);
        check("unmapped err", err, 1'b1);
    endtask

    // single-register modes, overflow set, clear and left alone
    task automatic t_single();
        run_op(cmd(SEL_A_ONLY, 3'h0, 9'h008), P1, P2);
        run_op(cmd(SEL_A_ONLY, 3'h1, 9'h008), P1, P2);
        run_op(cmd(SEL_A_ONLY, 3'h2, 9'h008), P1, P2);
        run_op(cmd(SEL_B_ONLY, 3'h0, 9'h00B), P2, P1);
        run_op(cmd(SEL_A_ONLY, 3'h4, 9'h002), 24'h20_0000, P2);
        i_seq.xfer(1'b1, OFS_STAT, 32'h0000_0002, rdat, err);
        exp_ovf = 1'b0;
        run_op(cmd(SEL_A_ONLY, 3'h5, 9'h003), P2, P1);
        run_op(cmd(SEL_A_ONLY, 3'h6, 9'h005), P2, P1);
        run_op(cmd(SEL_B_ONLY, 3'h4, 9'h004), P1, P2);
        run_op(cmd(SEL_A_ONLY, 3'h0, 9'h009), P1, P2);
    endtask

    // double register as one 48-bit unit
    task automatic t_double();
        run_op(cmd(SEL_DOUBLE, 3'h0, 9'h005), 24'h80_0001, P2);
        run_op(cmd(SEL_DOUBLE, 3'h4, 9'h003), P2, P1);
        run_op(cmd(SEL_DOUBLE, 3'h1, 9'h01A), P1, P2);
        run_op(cmd(SEL_DOUBLE, 3'h2, 9'h01E), P1, P2);
        run_op(cmd(SEL_DOUBLE, 3'h7, 9'h02F), P1, P2);
    endtask

    // twin mode: both registers, no bits passing between them
    task automatic t_twin();
        run_op(cmd(SEL_TWIN, 3'h0, 9'h007), P1, P1);
        run_op(cmd(SEL_TWIN, 3'h5, 9'h009), P1, P2);
        run_op(cmd(SEL_TWIN, 3'h1, 9'h00A), P1, P2);
        run_op(cmd(SEL_TWIN, 3'h2, 9'h00D), P2, P1);
        run_op(cmd(SEL_TWIN, 3'h4, 9'h001), P2, P1);
    endtask

    // count boundaries of both timing tables except the right 25/26 one, zero and clamping
    task automatic t_counts();
        for (int i = 0; i < 16; i++)
        begin
            run_op(cmd(SEL_A_ONLY, 3'h5, 9'(cnt_list[i])), P1, P2);
            run_op(cmd(SEL_B_ONLY, 3'h2, 9'(cnt_list[i])), P1, P2);
        end
    endtask

    // normalize request and writes refused while busy
    task automatic t_misc();
        run_op(cmd(SEL_DOUBLE, 3'h4, 9'h005) | 15'h4000, P1, P2);
        run_op(cmd(SEL_A_ONLY, 3'h0, 9'h030), P1, P2, 1'b1);
    endtask

    // reset, then the scenarios in turn
    initial
    begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_single();
        t_double();
        t_twin();
        t_counts();
        t_misc();
        end_of_test();
    end
endmodule // tb_top
